/* mt_pkg.sv */
/*
  Constants for the 8-bit modulo timer: register indices, field positions,
  reset values and source-select codes.
  Assumes a 32-bit APB slave where each register takes one aligned word.
*/
package mt_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h18;
  localparam logic [7:0] IDX_CLOCK_CONFIG   = 8'h19;
  localparam logic [7:0] IDX_COUNT_VALUE    = 8'h1A;
  localparam logic [7:0] IDX_MODULO_LIMIT   = 8'h1B;
  localparam int         ADDR_W             = 10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SC_TOF_BIT    = 7;
  localparam int SC_OVERFLOW_IRQ_ENABLE_BIT   = 6;
  localparam int SC_CLR_BIT    = 5;
  localparam int SC_HALT_BIT   = 4;
  localparam int CLK_SRC_LSB   = 4;
  localparam int CLK_PS_LSB    = 0;

  // ----------------------------------------------------------------
  // Reset values and count limits
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_STATUS_CONTROL = 8'h10;
  localparam logic [7:0] RST_CLOCK_CONFIG   = 8'h00;
  localparam logic [7:0] RST_COUNT_VALUE    = 8'h00;
  localparam logic [7:0] RST_MODULO_LIMIT   = 8'h00;
  localparam logic [7:0] COUNT_ZERO         = 8'h00;
  localparam logic [7:0] COUNT_FULL         = 8'hFF;

  // ----------------------------------------------------------------
  // Source select and prescale codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_BUS_CLOCK = 2'h0;
  localparam logic [1:0] SRC_FIXED     = 2'h1;
  localparam logic [1:0] SRC_EXT_FALL  = 2'h2;
  localparam logic [1:0] SRC_EXT_RISE  = 2'h3;
  localparam logic [3:0] PS_MAX        = 4'h8;

endpackage

/* mt_timer.sv */
/*
  Modulo timer: 8-bit up-counter with prescaler, four byte registers
  reached over APB, overflow flag and level interrupt request.
  Assumes stop_mode and debug_mode come from logic on pclk; the external
  count clock and the fixed-frequency clock are asynchronous levels.
*/
// Decided for this implementation: register access over APB.
// Overview of operation
// RL1: In stop mode all counting freezes; the timer never wakes the chip.
// RL2: Leaving deep stop by reset returns registers and counter to reset.
// RL3: Leaving deep stop by interrupt keeps state; counting resumes from count.
// RL4: In background debug mode counting is suspended.
// RL5: After debug, count resumes unless reset, clear bit or modulo write.
// RL6: External count clock is used only when selected as source.
// RL7: External count clock is synchronised to the bus clock before use.
// RL8: External count clock must stay at or below a quarter bus rate.
// RL9: Overflow flag bit 7 sets when counter rolls over to zero.
// RL10: Flag clears only by reading it set, then writing zero.
// RL11: Flag also clears on counter-clear write or any modulo write.
// RL12: Interrupt requested when enable bit 6 and the flag are set.
// RL13: Software clears a pending flag before setting the enable.
// RL14: Writing one to bit 5 zeroes counter and flag; reads zero.
// RL15: Halt bit 4 holds the counter; reset sets it.
// RL16: Reserved status bits read zero and ignore writes.
// RL17: Four byte registers; reset 10h for status, 00h for others.
// RL18: Count register is read-only and shows the counter.
// RL19: Source select: bus clock, fixed clock, pin falling, pin rising.
// RL20: Prescale divides by two to the code; codes above 8 give 256.
// RL21: Modulo zero means free-running; modulo write zeroes the count.
// RL22: Changing source or prescale does not clear the counter.
// RL23: Counter steps per prescaler tick; wraps after modulo or FFh.
// RL24: Interrupt request is a level while flag and enable stay set.
`timescale 1ns/10ps

module mt_timer (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Chip mode
  input  wire logic        stop_mode,
  input  wire logic        debug_mode,
  // Count sources
  input  wire logic        fixed_freq_clock,
  input  wire logic        ext_count_clock,
  // Interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic       ack_q;
  logic [31:0] prdata_q;
  logic       slverr_q;
  logic       tof_q;
  logic       overflow_irq_enable_q;
  logic       halt_q;
  logic       armed_q;
  logic [1:0] src_q;
  logic [3:0] ps_q;
  logic [7:0] cnt_q;
  logic [7:0] mod_q;
  logic [7:0] presc_q;
  logic       ext_s1_q, ext_s2_q, ext_s3_q;
  logic       fix_s1_q, fix_s2_q, fix_s3_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [7:0] idx;
  logic       access, wr_en, rd_en, hit;
  logic       sel_sc, sel_clk, sel_cnt, sel_mod;
  logic       sc_wr, cnt_clr, tof_clr_wr;

  assign idx     = paddr[9:2];
  assign sel_sc  = idx == mt_pkg::IDX_STATUS_CONTROL; // RL17
  assign sel_clk = idx == mt_pkg::IDX_CLOCK_CONFIG;
  assign sel_cnt = idx == mt_pkg::IDX_COUNT_VALUE;
  assign sel_mod = idx == mt_pkg::IDX_MODULO_LIMIT;
  assign hit     = (sel_sc | sel_clk | sel_cnt | sel_mod)
                   & (paddr[1:0] == 2'h0);
  assign access  = psel & penable;
  assign wr_en   = access & ack_q & pwrite & hit;
  assign rd_en   = access & ack_q & ~pwrite & hit;
  assign sc_wr   = wr_en & sel_sc;
  // Counter clear sources: clear bit or modulo write
  assign cnt_clr = (sc_wr & pwdata[mt_pkg::SC_CLR_BIT])
                   | (wr_en & sel_mod); // RL14 RL21
  // Zero written to the flag counts only after an armed read
  assign tof_clr_wr = sc_wr & ~pwdata[mt_pkg::SC_TOF_BIT] & armed_q; // RL10

  // One wait state so that read data comes straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  assign pready  = ack_q;
  assign prdata  = prdata_q;
  assign pslverr = slverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (access & ~ack_q) begin
      slverr_q <= ~hit;
      prdata_q <= 32'h0000_0000;
      if (!pwrite && sel_sc) begin
        // Clear bit and low reserved bits read zero
        prdata_q[mt_pkg::SC_TOF_BIT]  <= tof_q; // RL16
        prdata_q[mt_pkg::SC_OVERFLOW_IRQ_ENABLE_BIT] <= overflow_irq_enable_q;
        prdata_q[mt_pkg::SC_HALT_BIT] <= halt_q;
      end else if (!pwrite && sel_clk) begin
        prdata_q[mt_pkg::CLK_SRC_LSB +: 2] <= src_q;
        prdata_q[mt_pkg::CLK_PS_LSB +: 4]  <= ps_q;
      end else if (!pwrite && sel_cnt) begin
        prdata_q[7:0] <= cnt_q; // RL18
      end else if (!pwrite && sel_mod) begin
        prdata_q[7:0] <= mod_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Async reset also covers leaving deep stop by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_q <= mt_pkg::RST_STATUS_CONTROL[mt_pkg::SC_OVERFLOW_IRQ_ENABLE_BIT]; // RL2 RL12
      halt_q <= mt_pkg::RST_STATUS_CONTROL[mt_pkg::SC_HALT_BIT]; // RL15
      src_q  <= mt_pkg::RST_CLOCK_CONFIG[mt_pkg::CLK_SRC_LSB +: 2];
      ps_q   <= mt_pkg::RST_CLOCK_CONFIG[mt_pkg::CLK_PS_LSB +: 4];
      mod_q  <= mt_pkg::RST_MODULO_LIMIT;
    end else begin
      if (sc_wr) begin
        overflow_irq_enable_q <= pwdata[mt_pkg::SC_OVERFLOW_IRQ_ENABLE_BIT];
        halt_q <= pwdata[mt_pkg::SC_HALT_BIT];
      end
      // Count is left alone here: new ratio applies from next tick
      if (wr_en && sel_clk) begin
        src_q <= pwdata[mt_pkg::CLK_SRC_LSB +: 2]; // RL22
        ps_q  <= pwdata[mt_pkg::CLK_PS_LSB +: 4];
      end
      if (wr_en && sel_mod) begin
        mod_q <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
      fix_s1_q <= 1'b0;
      fix_s2_q <= 1'b0;
      fix_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_count_clock; // RL7
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      fix_s1_q <= fixed_freq_clock;
      fix_s2_q <= fix_s1_q;
      fix_s3_q <= fix_s2_q;
    end
  end

  logic src_tick;
  always_comb begin
    unique case (src_q) // RL19
      mt_pkg::SRC_BUS_CLOCK: src_tick = 1'b1;
      mt_pkg::SRC_FIXED:     src_tick = fix_s2_q & ~fix_s3_q;
      mt_pkg::SRC_EXT_FALL:  src_tick = ~ext_s2_q & ext_s3_q; // RL6
      mt_pkg::SRC_EXT_RISE:  src_tick = ext_s2_q & ~ext_s3_q; // RL6
    endcase
  end

  // ----------------------------------------------------------------
  // Prescaler and counter
  // ----------------------------------------------------------------
  logic       run, tick, wrap, ovf_evt;
  logic [7:0] pmask;
  logic [3:0] ps_eff;

  // Stop, debug and halt all freeze the prescaler and the count
  assign run    = ~halt_q & ~stop_mode & ~debug_mode; // RL1 RL4 RL15
  assign ps_eff = (ps_q > mt_pkg::PS_MAX) ? mt_pkg::PS_MAX : ps_q; // RL20
  assign pmask  = 8'(({1'b0, mt_pkg::COUNT_FULL} + 9'h001) >> (4'h8 - ps_eff))
                  - 8'h01;
  assign tick   = run & src_tick & ((presc_q & pmask) == pmask); // RL23
  assign wrap   = (mod_q == mt_pkg::COUNT_ZERO) ?
                  (cnt_q == mt_pkg::COUNT_FULL) : (cnt_q == mod_q); // RL21
  assign ovf_evt = tick & wrap & ~cnt_clr;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= mt_pkg::COUNT_ZERO;
    end else if (cnt_clr) begin
      presc_q <= mt_pkg::COUNT_ZERO;
    end else if (run && src_tick) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // Held value survives stop, debug and halt untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= mt_pkg::RST_COUNT_VALUE; // RL2
    end else if (cnt_clr) begin
      cnt_q <= mt_pkg::COUNT_ZERO; // RL5 RL14 RL21
    end else if (tick) begin
      cnt_q <= wrap ? mt_pkg::COUNT_ZERO : cnt_q + 8'h01; // RL23 RL3
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tof_q <= mt_pkg::RST_STATUS_CONTROL[mt_pkg::SC_TOF_BIT];
    end else if (ovf_evt) begin
      tof_q <= 1'b1; // RL9
    end else if (cnt_clr || tof_clr_wr) begin
      tof_q <= 1'b0; // RL10 RL11
    end
  end

  // Arms on a status read that sees the flag set; any status write disarms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_q <= 1'b0;
    end else if (rd_en && sel_sc) begin
      armed_q <= tof_q; // RL10
    end else if (sc_wr || !tof_q) begin
      armed_q <= 1'b0;
    end
  end

  assign irq = tof_q & overflow_irq_enable_q; // RL12 RL24

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence armed_read_s;
    rd_en && sel_sc && tof_q;
  endsequence
  sequence zero_write_s;
    sc_wr && !pwdata[mt_pkg::SC_TOF_BIT] && !ovf_evt;
  endsequence

  tof_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RL9
    ovf_evt |=> tof_q && cnt_q == mt_pkg::COUNT_ZERO)
    else $error("overflow did not set flag and zero count");
  tof_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    armed_read_s ##[1:20] zero_write_s |=> !tof_q)
    else $error("armed zero write did not clear flag");
  tof_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    zero_write_s and (!armed_q && !cnt_clr && tof_q) |=> tof_q)
    else $error("flag cleared without prior read");
  clr_bit_a: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    cnt_clr |=> cnt_q == mt_pkg::COUNT_ZERO && !tof_q)
    else $error("counter clear left count or flag");
  stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    stop_mode && !cnt_clr |=> $stable(cnt_q) && !$rose(tof_q))
    else $error("counter moved in stop mode");
  dbg_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    debug_mode && !cnt_clr |=> cnt_q == $past(cnt_q))
    else $error("counter moved in debug mode");
  halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    halt_q && !cnt_clr |=> $stable(cnt_q))
    else $error("counter moved while halted");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn) // RL24
    ovf_evt && overflow_irq_enable_q && !sc_wr |=> irq)
    else $error("interrupt missing after overflow");
  bus_rate_a: assert property (@(posedge pclk) disable iff (!presetn) // RL23
    run && src_q == mt_pkg::SRC_BUS_CLOCK && ps_q == 4'h0 && !cnt_clr
    && !wrap |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("counter not stepping on bus clock");
  rsvd_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    access && !ack_q && !pwrite && sel_sc |=> prdata[3:0] == 4'h0
    && !prdata[mt_pkg::SC_CLR_BIT])
    else $error("reserved status bits not zero");

  // ----------------------------------------------------------------
  // Flag arming and interrupt mask checks
  // ----------------------------------------------------------------
  // The flag clear needs a read first, so the arm is checked on its own
  arm_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RL10
    armed_read_s |=> armed_q)
    else $error("read of a set flag did not arm the clear");
  irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    !overflow_irq_enable_q |-> !irq)
    else $error("interrupt raised while disabled");

  // ----------------------------------------------------------------
  // Bus handshake checks
  // ----------------------------------------------------------------
  // Every transfer waits exactly one cycle, so the answer never races
  // the registered read data
  sequence bus_setup_s;
    psel && !penable;
  endsequence
  sequence bus_first_s;
    psel && penable && !ack_q;
  endsequence

  ready_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    bus_setup_s ##1 bus_first_s |=> pready)
    else $error("ready not raised after one wait state");
  ready_one_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    pready |=> !pready)
    else $error("ready held for more than one cycle");
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    bus_first_s and (!hit) |=> pready && pslverr)
    else $error("unmapped access answered without error");
  good_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    bus_first_s and (hit) |=> pready && !pslverr)
    else $error("mapped access answered with error");
  cnt_read_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    bus_first_s and (!pwrite && sel_cnt)
    |=> prdata[7:0] == $past(cnt_q))
    else $error("count read did not return the counter");

  // ----------------------------------------------------------------
  // Counter and prescaler checks
  // ----------------------------------------------------------------
  // A cycle with no tick and no clear must leave the count untouched
  sequence no_step_s;
    !tick && !cnt_clr;
  endsequence

  cnt_ro_a: assert property (@(posedge pclk) disable iff (!presetn) // RL18
    no_step_s and (wr_en && sel_cnt) |=> $stable(cnt_q))
    else $error("write to count register moved the counter");
  cfg_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // RL22
    no_step_s and (wr_en && sel_clk) |=> $stable(cnt_q))
    else $error("clock reconfiguration moved the counter");
  free_run_a: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    tick && !cnt_clr && mod_q == mt_pkg::COUNT_ZERO
    && cnt_q != mt_pkg::COUNT_FULL |=> cnt_q == $past(cnt_q) + 8'h01)
    else $error("free-running counter did not step");
  mod_bound_a: assert property (@(posedge pclk) disable iff (!presetn) // RL23
    mod_q != mt_pkg::COUNT_ZERO |-> cnt_q <= mod_q)
    else $error("counter passed the modulo value");
  ps_half_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    tick && ps_q == 4'h1 && !(wr_en && sel_clk) |=> !tick)
    else $error("divide by two ticked twice in a row");
  ps_clamp_a: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    ps_q > mt_pkg::PS_MAX |-> pmask == mt_pkg::COUNT_FULL)
    else $error("large prescale code not clamped to 256");
  src_bus_a: assert property (@(posedge pclk) disable iff (!presetn) // RL19
    src_q == mt_pkg::SRC_BUS_CLOCK |-> src_tick)
    else $error("bus clock source missed a tick");
  stop_tick_a: assert property (@(posedge pclk) disable iff (!presetn) // RL1
    stop_mode |-> !tick)
    else $error("prescaler ticked in stop mode");
  clr_presc_a: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    cnt_clr |=> presc_q == mt_pkg::COUNT_ZERO)
    else $error("counter clear left the prescaler running");
  pin_quiet_a: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    src_q[1] && ext_s2_q == ext_s3_q |-> !src_tick)
    else $error("pin source ticked without a pin edge");

endmodule // mt_timer

/* tb.sv */
/*
  Self-checking testbench for the modulo timer: drives APB, chip modes
  and both count pins from the bench, and checks registers, count and irq.
  Assumes mt_pkg and mt_timer are compiled first; the APB slave answers
  with one wait state; pclk runs at 40 MHz.
*/
`timescale 1ns/10ps

module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        stop_mode, debug_mode, fixed_freq_clock, ext_count_clock;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        er;
  int          n_mismatch, samples_checked, t, k, per;
  logic [7:0]  m;
  logic [3:0]  p;
  localparam logic [9:0] A_SC  = {mt_pkg::IDX_STATUS_CONTROL, 2'h0};
  localparam logic [9:0] A_CLK = {mt_pkg::IDX_CLOCK_CONFIG, 2'h0};
  localparam logic [9:0] A_CNT = {mt_pkg::IDX_COUNT_VALUE, 2'h0};
  localparam logic [9:0] A_MOD = {mt_pkg::IDX_MODULO_LIMIT, 2'h0};

  mt_timer mt_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stop_mode(stop_mode), .debug_mode(debug_mode),
    .fixed_freq_clock(fixed_freq_clock),
    .ext_count_clock(ext_count_clock), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Tasks and expectation functions
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; one idle edge after release
  task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    // Look between edges so the ready flop is settled, not racing
    do begin
      @(negedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("ERROR pready expected 1 seen %b", pready);
      give_verdict();
    end else begin
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rdchk(input logic [9:0] a, input logic [7:0] e, string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  // Debug freeze is lifted for exactly k counting edges
  task automatic run(input int k);
    debug_mode <= 1'b0;
    repeat (k) @(posedge pclk);
    debug_mode <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic setup(input logic [7:0] md, input logic [7:0] ck);
    apb(1'b1, A_MOD, md);
    apb(1'b1, A_CLK, ck);
    apb(1'b1, A_SC, 8'h00);
  endtask

  task automatic chk_reset();
    rdchk(A_SC, mt_pkg::RST_STATUS_CONTROL, "sc reset");
    rdchk(A_CLK, mt_pkg::RST_CLOCK_CONFIG, "clk reset");
    rdchk(A_CNT, mt_pkg::RST_COUNT_VALUE, "cnt reset");
    rdchk(A_MOD, mt_pkg::RST_MODULO_LIMIT, "mod reset");
  endtask

  function automatic int period(input logic [7:0] md);
    return (md == 8'h00) ? 256 : int'(md) + 1;
  endfunction

  function automatic int divisor(input logic [3:0] ps);
    return (ps > 4'h8) ? 256 : (1 << ps);
  endfunction

  // Fixed pin pulses three times; the count pin rises five, falls four
  function automatic logic [7:0] pin_ticks(input int s);
    return (s == 1) ? 8'h03 : ((s == 2) ? 8'h04 : 8'h05);
  endfunction

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 10'h000; pwdata = 32'h0; stop_mode = 1'b0; debug_mode = 1'b1;
    fixed_freq_clock = 1'b0; ext_count_clock = 1'b0;
    n_mismatch = 0; samples_checked = 0;
    rd = $urandom(32'hC170);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_reset();
    apb(1'b1, A_CNT, 8'h55);
    rdchk(A_CNT, 8'h00, "cnt write ignored");
    apb(1'b1, 10'h3F0, 8'hAA);
    chk("unmapped error", 32'h1, {31'h0, er});
    $display("test reset and map done");

    for (int i = 0; i < 8; i++) begin
      m = 8'($urandom); p = 4'($urandom % 4); k = $urandom_range(1, 600);
      if (i == 0) begin m = 8'h00; p = 4'h0; k = 300; end
      if (i == 1) begin m = 8'h01; p = 4'h9; k = 600; end
      setup(m, {4'h0, p});
      run(k);
      t = k / divisor(p); per = period(m);
      rdchk(A_CNT, 8'(t % per), "count after run");
      apb(1'b0, A_SC, 8'h00);
      chk("flag after run", {31'h0, t >= per}, {31'h0, rd[7]});
      run(5);
      t = (k + 5) / divisor(p);
      rdchk(A_CNT, 8'(t % per), "count resumed");
      apb(1'b1, A_CLK, 8'h15);
      rdchk(A_CNT, 8'(t % per), "count kept on reconfig");
    end
    $display("test modulo runs done");

    setup(8'h03, 8'h00);
    run(4);
    apb(1'b1, A_SC, 8'h10);
    rdchk(A_SC, 8'h90, "flag kept without read");
    apb(1'b1, A_SC, 8'h10);
    rdchk(A_SC, 8'h10, "flag cleared after read");
    apb(1'b1, A_SC, 8'h50);
    chk("irq idle", 32'h0, {31'h0, irq});
    apb(1'b1, A_SC, 8'h40);
    run(4);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdchk(A_SC, 8'hC0, "sc with flag");
    run(2);
    apb(1'b1, A_SC, 8'h60);
    rdchk(A_CNT, 8'h00, "count cleared");
    rdchk(A_SC, 8'h40, "flag cleared by clear bit");
    chk("irq dropped", 32'h0, {31'h0, irq});
    run(6);
    apb(1'b1, A_MOD, 8'h03);
    rdchk(A_SC, 8'h40, "flag cleared by modulo");
    rdchk(A_CNT, 8'h00, "count zero on modulo");
    apb(1'b1, A_SC, 8'h2F);
    rdchk(A_SC, 8'h00, "reserved bits");
    $display("test flag and irq done");

    setup(8'h00, 8'h00);
    stop_mode <= 1'b1;
    run(50);
    stop_mode <= 1'b0;
    rdchk(A_CNT, 8'h00, "stop freezes");
    run(10);
    rdchk(A_CNT, 8'h0A, "count resumes after stop");
    $display("test stop done");

    for (int s = 1; s < 4; s++) begin
      setup(8'h00, {2'h0, 2'(s), 4'h0});
      debug_mode <= 1'b0;
      // Pins toggle every 4 cycles, well under a quarter of pclk
      for (int j = 0; j < 5; j++) begin
        ext_count_clock <= 1'b1;
        if (j < 3) fixed_freq_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_count_clock <= (j == 4);
        fixed_freq_clock <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      debug_mode <= 1'b1;
      @(posedge pclk);
      rdchk(A_CNT, pin_ticks(s), "pin source count");
      ext_count_clock <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    $display("test count sources done");

    setup(8'h05, 8'h03);
    run(20);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_reset();
    $display("test reset mid run done");
    give_verdict();
  end
endmodule // tb
